// [design/eeprom_pkg.sv]
// eeprom_pkg: constants, select-byte layout and state type of the serial eeprom slave engine.
// assumes a 200 MHz system clock; the serial bus clock is an unrelated link clock.
`default_nettype none
package eeprom_pkg;
   // system clock rate and the self-timed programming time
   localparam int CLK_FREQ_HZ   = 200_000_000;
   localparam int CLK_PER_US    = CLK_FREQ_HZ / 1_000_000;
   localparam int WRITE_TIME_US = 10_000;                       // longest programming time
   localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_PER_US;   // exact, so rounding down changes nothing

   // array geometry: the larger option keeps 15 address bits, the smaller 14
   localparam int ADDR_W_LARGE  = 15;
   localparam int ADDR_W_SMALL  = 14;
   localparam int PAGE_W        = 6;                             // bits that roll over inside a row
   localparam int PAGE_BYTES    = 64;

   // bit slot counter: bits taken so far in the current frame
   localparam logic [3:0] SLOT_RESET = 4'h0;                     // frame start
   localparam logic [3:0] SLOT_FIRST = 4'h1;                     // one clock rise after the ack slot
   localparam logic [3:0] SLOT_ACK   = 4'h8;                     // eight bits in, ack slot next
   localparam logic [3:0] SLOT_DONE  = 4'h9;                     // ack slot clock has risen

   // values after reset
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [63:0] MASK_RESET = 64'h0000_0000_0000_0000;
   localparam logic [7:0]  BYTE_RESET = 8'h00;

   // memory type code; the value is arbitrary
   localparam logic [3:0] TYPE_CODE_DEFAULT = 4'h5;

   // select byte as it arrives, msb first
   typedef struct packed {
      logic [3:0] dev_type;                                      // fixed memory type field
      logic [2:0] enable;                                        // compared with the straps
      logic       rd;                                            // 1 read, 0 write
   } select_t;

   // protocol engine states
   typedef enum logic [2:0] {
      idle, dev_select, addr_hi, addr_lo, write_data, read_data, programming
   } state_t;
endpackage : eeprom_pkg
`default_nettype wire

// [design/i2c_serial_eeprom_slave.sv]
// i2c_serial_eeprom_slave: slave protocol engine and array of a two-wire serial eeprom.
// assumes scl and sda come straight from pins; scl clocks the bit capture, everything else runs on clk.
// the pad combines sda_out/sda_oe as open drain; the bus needs an external pull-up.
//
// Operation
// - sample data on each rising serial clock
// - select byte: type, enables, direction, msb first
// - respond only when type and straps match
// - direction bit one reads, zero writes
// - ack on match, else release, go standby
// - two address bytes, upper first, top bits ignored
// - write select: ack two address bytes, then data
// - protect high before address end: nack data
// - byte write acked and scheduled when unprotected
// - page write up to 64 bytes, one row
// - write increments low six address bits only
// - program only on stop in tenth slot
// - during programming ignore bus, never acknowledge
// - reads ignore the write protect input
// - random read: dummy write, restart, read select
// - acked reads continue, counter wraps to zero
// - read nack in ninth slot ends transfer
// - start: data falls, stop: data rises, clock high
// - protect high still acks select and address
`timescale 1ns/100ps
`default_nettype none
module i2c_serial_eeprom_slave #(
   parameter int         ADDR_W       = eeprom_pkg::ADDR_W_LARGE,       // 14 for the smaller option
   parameter int         WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,       // programming time in clk cycles
   parameter logic [3:0] TYPE_CODE    = eeprom_pkg::TYPE_CODE_DEFAULT   // arbitrary value
) (
   // system clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // serial bus: link clock and open-drain data
   input  wire logic scl,
   input  wire logic sda_in,
   output var  logic sda_out,
   output var  logic sda_oe,
   // straps and write protect
   input  wire logic strap_select_bit0,
   input  wire logic strap_select_bit1,
   input  wire logic strap_select_bit2,
   input  wire logic write_protect_in,
   // status
   output var  logic busy
);
   localparam int DEPTH  = 1 << ADDR_W;
   localparam int BUSY_W = $clog2(WRITE_CYCLES + 1);
   localparam int PW     = eeprom_pkg::PAGE_W;

   // ---------------------------------------------------------------- link domain
   logic link_bit;                          // data level at the last scl rise
   logic link_tog;                          // flips once per scl rise

   // capture each bit on the rising serial clock; held until the next rise, so the
   // clk side may read link_bit freely once it has seen the toggle
   always_ff @(posedge scl or posedge rst) begin
      if (rst) begin
         link_bit <= 1'b0;
         link_tog <= 1'b0;
      end else begin
         link_bit <= sda_in;
         link_tog <= ~link_tog;
      end
   end

   // ---------------------------------------------------------------- synchronisers
   logic       scl_s1, scl_s2, scl_s3;      // serial clock level, third stage for edges
   logic       sda_s1, sda_s2, sda_s3;      // data level, third stage for edges
   logic       tog_s1, tog_s2, tog_s3;      // bit toggle crossing
   logic       wp_s1,  wp_s2;               // write protect level
   logic [2:0] strap_s1, strap_s2;          // chip select straps

   // two flops on every pin and on the toggle; only stage two and later are read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;  // idle bus is high
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
         {tog_s1, tog_s2, tog_s3} <= 3'h0;
         {wp_s1, wp_s2}           <= 2'h0;
         strap_s1                 <= 3'h0;
         strap_s2                 <= 3'h0;
      end else begin
         {scl_s1, scl_s2, scl_s3} <= {scl, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
         {tog_s1, tog_s2, tog_s3} <= {link_tog, tog_s1, tog_s2};
         {wp_s1, wp_s2}           <= {write_protect_in, wp_s1};
         strap_s1                 <= {strap_select_bit2, strap_select_bit1, strap_select_bit0};
         strap_s2                 <= strap_s1;
      end
   end

   // ---------------------------------------------------------------- state
   eeprom_pkg::state_t state;               // protocol engine state
   logic [3:0]         slot;                // bits taken in the current frame
   logic [7:0]         shreg;               // received byte
   logic [7:0]         txreg;               // byte being sent
   logic               rd_dir;              // direction of the accepted select byte
   logic [15:0]        addr;                // internal address counter
   logic               wp_seen;             // protect seen since start
   logic [7:0]         page_buf [0:eeprom_pkg::PAGE_BYTES-1];   // scheduled bytes
   logic [63:0]        page_mask;           // which page bytes are scheduled
   logic [7:0]         mem [0:DEPTH-1];     // the array
   logic [BUSY_W-1:0]  busy_cnt;            // programming time left
   logic [PW:0]        copy_idx;            // page byte being committed, msb = finished

   // ---------------------------------------------------------------- decode
   wire logic                bit_ev   = tog_s2 ^ tog_s3;            // a clock rise was captured
   wire logic                scl_fall = scl_s3 & ~scl_s2;
   wire logic                start_ev = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   wire logic                stop_ev  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   wire eeprom_pkg::select_t rx_sel   = eeprom_pkg::select_t'(shreg);
   wire logic                sel_match = (rx_sel.dev_type == TYPE_CODE)
                                       && (rx_sel.enable == strap_s2);
   wire logic                in_prog  = (state == eeprom_pkg::programming);
   wire logic                in_addr  = (state == eeprom_pkg::dev_select) || (state == eeprom_pkg::addr_hi)
                                       || (state == eeprom_pkg::addr_lo);
   wire logic                ack_fall = scl_fall && (slot == eeprom_pkg::SLOT_ACK);
   wire logic                done_fall = scl_fall && (slot == eeprom_pkg::SLOT_DONE);
   wire logic [ADDR_W-1:0]   mem_addr = addr[ADDR_W-1:0];
   wire logic [7:0]          rd_byte  = mem[mem_addr];
   wire logic [15:0]         next_seq_addr  = addr + 16'h0001;
   wire logic [15:0]         next_page_addr = {addr[15:PW], PW'(addr[PW-1:0] + 1'b1)};
   wire logic [7:0]          next_shreg     = {shreg[6:0], link_bit};
   // a data byte of a write frame is taken into the page buffer
   wire logic                buf_we   = ack_fall && (state == eeprom_pkg::write_data) && !wp_seen;
   // address phase over: a fresh page starts
   wire logic                buf_clr  = done_fall && (state == eeprom_pkg::addr_lo);
   // stop right after an acked data byte, i.e. in the first slot of the next frame
   wire logic                prog_go  = stop_ev && (state == eeprom_pkg::write_data)
                                       && (slot == eeprom_pkg::SLOT_FIRST)
                                       && (page_mask != eeprom_pkg::MASK_RESET) && !wp_seen;
   wire logic                commit   = in_prog && !copy_idx[PW];
   wire logic                prog_done = in_prog && (busy_cnt == '0) && copy_idx[PW];

   // ---------------------------------------------------------------- protocol engine
   // one clocked process; start, stop and clock edges never fall in the same cycle,
   // because each needs the other line stable for hundreds of nanoseconds
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state  <= eeprom_pkg::idle;
         slot   <= eeprom_pkg::SLOT_RESET;
         shreg  <= eeprom_pkg::BYTE_RESET;
         txreg  <= eeprom_pkg::BYTE_RESET;
         rd_dir <= 1'b0;
         addr   <= eeprom_pkg::ADDR_RESET;
         sda_oe <= 1'b0;
         busy   <= 1'b0;
      end else if (in_prog) begin
         // deaf to the bus until the page is committed and the time has run out
         sda_oe <= 1'b0;
         if (prog_done) begin
            state <= eeprom_pkg::idle;
            busy  <= 1'b0;
         end
      end else if (start_ev) begin
         // start or repeated start: the address counter survives for random reads
         state  <= eeprom_pkg::dev_select;
         slot   <= eeprom_pkg::SLOT_RESET;
         sda_oe <= 1'b0;
      end else if (stop_ev) begin
         // any stop ends the frame; only the tenth slot one programs
         sda_oe <= 1'b0;
         slot   <= eeprom_pkg::SLOT_RESET;
         state  <= prog_go ? eeprom_pkg::programming : eeprom_pkg::idle;
         busy   <= prog_go;
      end else if (state != eeprom_pkg::idle) begin
         // rising edge: shift a bit in, or read the master's answer in the ack slot
         if (bit_ev) begin
            if (slot < eeprom_pkg::SLOT_ACK) begin
               shreg <= next_shreg;
               slot  <= slot + 4'h1;
            end else if (slot == eeprom_pkg::SLOT_ACK) begin
               slot <= eeprom_pkg::SLOT_DONE;
               if (state == eeprom_pkg::read_data && link_bit) begin
                  state <= eeprom_pkg::idle;
               end
            end
         end
         // falling edge: change what we put on the line
         if (ack_fall) begin
            unique case (state)
               eeprom_pkg::dev_select: begin
                  if (sel_match) begin
                     sda_oe <= 1'b1;
                     rd_dir <= rx_sel.rd;
                  end else begin
                     state <= eeprom_pkg::idle;
                  end
               end
               eeprom_pkg::addr_hi: begin
                  sda_oe     <= 1'b1;
                  addr[15:8] <= shreg;
               end
               eeprom_pkg::addr_lo: begin
                  sda_oe    <= 1'b1;
                  addr[7:0] <= shreg;
               end
               eeprom_pkg::write_data: begin
                  sda_oe <= ~wp_seen;
                  if (!wp_seen) begin
                     addr <= next_page_addr;
                  end
               end
               default: begin
                  sda_oe <= 1'b0;                          // read: the master answers
               end
            endcase
         end else if (done_fall) begin
            slot   <= eeprom_pkg::SLOT_RESET;
            sda_oe <= 1'b0;
            unique case (state)
               eeprom_pkg::dev_select: begin
                  if (rd_dir) begin
                     // current address read, never gated by protect
                     state  <= eeprom_pkg::read_data;
                     txreg  <= rd_byte;
                     sda_oe <= ~rd_byte[7];
                     addr   <= next_seq_addr;
                  end else begin
                     state <= eeprom_pkg::addr_hi;
                  end
               end
               eeprom_pkg::addr_hi: state <= eeprom_pkg::addr_lo;
               eeprom_pkg::addr_lo: state <= eeprom_pkg::write_data;
               eeprom_pkg::read_data: begin
                  // master acked: next byte from the following address
                  txreg  <= rd_byte;
                  sda_oe <= ~rd_byte[7];
                  addr   <= next_seq_addr;
               end
               default: begin
                  sda_oe <= 1'b0;
               end
            endcase
         end else if (scl_fall && state == eeprom_pkg::read_data) begin
            // remaining seven data bits, only ever pulled low
            sda_oe <= ~txreg[6];
            txreg  <= {txreg[6:0], 1'b0};
         end
      end
   end

   // ---------------------------------------------------------------- write protect
   // sticky from the start through the end of the second address byte
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_seen <= 1'b0;
      end else if (!in_prog && start_ev) begin
         wp_seen <= wp_s2;
      end else if (in_addr && wp_s2) begin
         wp_seen <= 1'b1;
      end
   end

   // ---------------------------------------------------------------- page buffer
   // data bytes are only scheduled here; the array changes during programming,
   // so a frame that ends without a proper stop leaves the array alone
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         page_mask <= eeprom_pkg::MASK_RESET;
      end else if (buf_clr) begin
         page_mask <= eeprom_pkg::MASK_RESET;
      end else if (buf_we) begin
         page_mask[addr[PW-1:0]] <= 1'b1;
      end
   end

   // buffer data has no reset: the mask says which entries mean anything
   always_ff @(posedge clk) begin
      if (buf_we) begin
         page_buf[addr[PW-1:0]] <= shreg;
      end
   end

   // ---------------------------------------------------------------- programming
   // programming time and page copy run side by side; busy ends when both are over
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_cnt <= '0;
         copy_idx <= '0;
      end else if (prog_go && !in_prog) begin
         busy_cnt <= BUSY_W'(WRITE_CYCLES - 1);
         copy_idx <= '0;
      end else if (in_prog) begin
         if (busy_cnt != '0) begin
            busy_cnt <= busy_cnt - 1'b1;
         end
         if (!copy_idx[PW]) begin
            copy_idx <= copy_idx + 1'b1;
         end
      end
   end

   // the array: one page byte per clock, all inside the addressed row
   always_ff @(posedge clk) begin
      if (commit && page_mask[copy_idx[PW-1:0]]) begin
         mem[{mem_addr[ADDR_W-1:PW], copy_idx[PW-1:0]}] <= page_buf[copy_idx[PW-1:0]];
      end
   end

   // ---------------------------------------------------------------- data pad
   // open drain: the output level is always low, only the enable moves
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end
endmodule : i2c_serial_eeprom_slave
`default_nettype wire

// [sim/eeprom_monitor.sv]
// eeprom_monitor: port checks of the serial eeprom slave engine.
// assumes scl phases of at least 20 clk; bound to the slave from tb_top.
`timescale 1ns/100ps
`default_nettype none
module eeprom_monitor #(
   parameter int WRITE_CYCLES = 100   // programming time in clk
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial bus and status
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic busy
);
   localparam int BUSY_MIN = WRITE_CYCLES - 2;   // slack for the stop synchroniser
   localparam int BUSY_MAX = WRITE_CYCLES + 2;
   int busy_cnt;                                 // cycles busy has stood so far
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // busy length counter, cleared while idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) busy_cnt <= 0;
      else busy_cnt <= busy ? busy_cnt + 1 : 0;
   end
   property p_pull_only; sda_oe |-> sda_out == 1'b0; endproperty
   a_pull_only: assert property (p_pull_only) else $error("data pad driven high");
   property p_low_phase; $rose(sda_oe) |-> !scl; endproperty
   a_low_phase: assert property (p_low_phase) else $error("data changed with clock high");
   property p_oe_stands; $rose(sda_oe) |=> sda_oe [*8]; endproperty
   a_oe_stands: assert property (p_oe_stands) else $error("data drive cut short");
   property p_quiet_busy; busy && $past(busy) |-> !sda_oe; endproperty
   a_quiet_busy: assert property (p_quiet_busy) else $error("bus answered while programming");
   property p_prog_on_stop; $rose(busy) |-> scl && sda_in; endproperty
   a_prog_on_stop: assert property (p_prog_on_stop) else $error("programming began without stop");
   property p_busy_max; busy_cnt <= BUSY_MAX; endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy too long");
   property p_busy_min; $fell(busy) |-> $past(busy_cnt) >= BUSY_MIN; endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy too short");
   property p_busy_hold; $rose(busy) |=> busy [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
endmodule : eeprom_monitor
`default_nettype wire

// [sim/i2c_master_model.sv]
// i2c_master_model: behavioural two-wire bus master for the eeprom slave.
// assumes the data wire is resolved outside with a pull-up; scl stands high between frames.
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
   // bus side
   output var logic scl,
   output var logic sda_m,
   input  wire logic sda_wire
);
   logic tick;   // 6 ns link base clock, phase unrelated to clk
   // 20 ticks per scl phase so the slave's synchronisers resolve order
   initial begin
      tick = 1'b0;
      scl = 1'b1;
      sda_m = 1'b1;
      #1.7;
      forever #3 tick = ~tick;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge tick);
   endtask : wt
   // start or repeated start: data falls while scl high
   task automatic start();
      wt(10);
      sda_m <= 1'b1;
      wt(10);
      scl <= 1'b1;
      wt(20);
      sda_m <= 1'b0;
      wt(20);
      scl <= 1'b0;
   endtask : start
   // stop: data rises while scl high, then the bus is released
   task automatic stop();
      wt(10);
      sda_m <= 1'b0;
      wt(10);
      scl <= 1'b1;
      wt(20);
      sda_m <= 1'b1;
      wt(40);
   endtask : stop
   // one bit slot; data set only while scl is low, sampled mid-high
   task automatic bit_slot(input logic b, output logic s);
      wt(10);
      sda_m <= b;
      wt(10);
      scl <= 1'b1;
      wt(10);
      s = sda_wire;
      wt(10);
      scl <= 1'b0;
   endtask : bit_slot
   // byte msb first plus the ack slot; send 8'hFF to read
   task automatic xfer(input logic [7:0] w, input logic mack, output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) bit_slot(w[i], r[i]);
      bit_slot(mack, ack);
   endtask : xfer
   // first n bits of a byte only, for aborted frames
   task automatic bits(input logic [7:0] w, input int n);
      logic s;
      for (int i = 0; i < n; i++) bit_slot(w[7-i], s);
   endtask : bits
endmodule : i2c_master_model
`default_nettype wire

// [sim/tb_top.sv]
// tb_top: self-checking bench of the serial eeprom slave with a bus master model.
// assumes a 200 MHz clk; programming time shortened through WRITE_CYCLES.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam int         N_PROG = 1000;     // short programming time keeps the run small
   localparam int         LIMIT  = 90_000;   // clk cycles before the run is cut off
   localparam logic [2:0] STRAPS = 3'b101;
   logic       clk, rst, scl, sda_m, sda_out, sda_oe, busy, wp, ack;
   logic [2:0] straps;
   logic [7:0] rd;
   int         n_mismatch, total_checks, cycles;
   wire logic  sda_wire = sda_m & ~sda_oe;   // pull-up; either party may pull low
   i2c_serial_eeprom_slave #(.WRITE_CYCLES(N_PROG)) u_dut (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .strap_select_bit0(straps[0]), .strap_select_bit1(straps[1]),
      .strap_select_bit2(straps[2]), .write_protect_in(wp), .busy(busy));
   i2c_master_model u_m (.scl(scl), .sda_m(sda_m), .sda_wire(sda_wire));
   task automatic tally_and_finish();
      if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: byte %h, wanted %h", $time, g, e);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: bit %b, wanted %b", $time, g, e);
      end
   endtask : chk_bit
   function automatic logic [7:0] sel(input logic [2:0] en, input logic rw);
      return {eeprom_pkg::TYPE_CODE_DEFAULT, en, rw};
   endfunction : sel
   // start, write select and both address bytes, each acked
   task automatic addr_phase(input logic [15:0] a);
      u_m.start();
      u_m.xfer(sel(STRAPS, 1'b0), 1'b1, rd, ack);
      chk_bit(ack, 1'b0);
      u_m.xfer(a[15:8], 1'b1, rd, ack);
      chk_bit(ack, 1'b0);
      u_m.xfer(a[7:0], 1'b1, rd, ack);
      chk_bit(ack, 1'b0);
   endtask : addr_phase
   task automatic write_seq(input logic [15:0] a, input logic [7:0] base, input int n, input logic exp_ack);
      addr_phase(a);
      for (int i = 0; i < n; i++) begin
         u_m.xfer(base + 8'(i), 1'b1, rd, ack);
         chk_bit(ack, exp_ack);
      end
      u_m.stop();
   endtask : write_seq
   // busy check, then poll with select until acked
   task automatic wait_prog(input logic exp_busy);
      int tries;
      repeat (10) @(posedge clk);
      chk_bit(busy, exp_busy);
      tries = 0;
      ack = 1'b1;
      while (ack !== 1'b0 && tries < 20) begin
         u_m.start();
         u_m.xfer(sel(STRAPS, 1'b0), 1'b1, rd, ack);
         u_m.stop();
         if (tries == 0 && exp_busy) chk_bit(ack, 1'b1);
         tries++;
      end
      chk_bit(ack, 1'b0);
   endtask : wait_prog
   // read n bytes, nack the last, then one more byte to see the bus released
   task automatic read_seq(input logic [15:0] a, input logic rnd, input int n, input logic [15:0] e);
      if (rnd) addr_phase(a);
      u_m.start();
      u_m.xfer(sel(STRAPS, 1'b1), 1'b1, rd, ack);
      chk_bit(ack, 1'b0);
      for (int i = 0; i < n; i++) begin
         u_m.xfer(8'hFF, i == n - 1, rd, ack);
         chk_byte(rd, e[8*i +: 8]);
      end
      u_m.xfer(8'hFF, 1'b1, rd, ack);
      chk_byte(rd, 8'hFF);
      u_m.stop();
   endtask : read_seq
   task automatic s_select();
      for (int en = 0; en < 8; en++) begin
         u_m.start();
         u_m.xfer(sel(en[2:0], 1'b0), 1'b1, rd, ack);
         chk_bit(ack, en[2:0] != STRAPS);
         u_m.stop();
      end
      u_m.start();
      u_m.xfer({eeprom_pkg::TYPE_CODE_DEFAULT ^ 4'h1, STRAPS, 1'b0}, 1'b1, rd, ack);
      chk_bit(ack, 1'b1);
      u_m.stop();
   endtask : s_select
   // page write past row end wraps to row start; b15 ignored on read back
   task automatic s_page();
      write_seq(16'h80BE, 8'hA0, 4, 1'b0);
      wait_prog(1'b1);
      read_seq(16'h00BE, 1'b1, 2, 16'hA1A0);
      read_seq(16'h0080, 1'b1, 1, 16'h00A2);
      read_seq(16'h0000, 1'b0, 1, 16'h00A3);
   endtask : s_page
   task automatic s_wrap();
      write_seq(16'h7FFF, 8'h5A, 1, 1'b0);
      wait_prog(1'b1);
      write_seq(16'h0000, 8'hC3, 1, 1'b0);
      wait_prog(1'b1);
      read_seq(16'h7FFF, 1'b1, 2, 16'hC35A);
   endtask : s_wrap
   task automatic s_protect();
      @(posedge clk);
      wp <= 1'b1;
      write_seq(16'h00BE, 8'h11, 1, 1'b1);
      wait_prog(1'b0);
      read_seq(16'h00BE, 1'b1, 1, 16'h00A0);
      @(posedge clk);
      wp <= 1'b0;
   endtask : s_protect
   // stop in mid byte must not program
   task automatic s_nostop();
      addr_phase(16'h0081);
      u_m.bits(8'h00, 4);
      u_m.stop();
      wait_prog(1'b0);
      read_seq(16'h0081, 1'b1, 1, 16'h00A3);
   endtask : s_nostop
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      rst = 1'b1;
      wp = 1'b0;
      straps = STRAPS;
      n_mismatch = 0;
      total_checks = 0;
      cycles = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      s_select();
      s_page();
      s_wrap();
      s_protect();
      s_nostop();
      tally_and_finish();
   end
endmodule : tb_top
bind i2c_serial_eeprom_slave eeprom_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (.clk(clk), .rst(rst),
   .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));
`default_nettype wire
